// [include/adc_pkg.sv]
// shared constants and carrier types for the pipelined converter output logic
package adc_pkg;
    localparam int RESULT_W      = 12;
    localparam int STAGE1_BITS   = 4;
    localparam int STAGE2_BITS   = 4;
    localparam int STAGE3_BITS   = 3;
    localparam int STAGE4_BITS   = 4;
    localparam int RAW_W         = STAGE1_BITS + STAGE2_BITS + STAGE3_BITS + STAGE4_BITS;
    localparam int LATENCY       = 3;
    localparam int SUM_W         = RESULT_W + 2;
    // stage weights: bit offsets of each estimate inside the corrected sum
    localparam int STAGE1_SHIFT  = 9;
    localparam int STAGE2_SHIFT  = 6;
    localparam int STAGE3_SHIFT  = 4;
    localparam int STAGE4_SHIFT  = 0;
    // overlap offset removed after summing the estimates
    localparam logic [SUM_W-1:0] OVERLAP_OFFSET = 14'h0248;
    localparam logic [SUM_W-1:0] CODE_MAX       = 14'h0fff;
    localparam logic [RESULT_W-1:0] CODE_TOP    = 12'hfff;
    localparam logic [RESULT_W-1:0] CODE_ZERO   = 12'h000;
    localparam real CLK_MHZ       = 40.0;
    localparam real MIN_CONV_KHZ  = 10.0;

    typedef struct packed {
        logic [STAGE1_BITS-1:0] s1;
        logic [STAGE2_BITS-1:0] s2;
        logic [STAGE3_BITS-1:0] s3;
        logic [STAGE4_BITS-1:0] s4;
    } raw_bits_t;

    typedef struct packed {
        logic                range_exceeded_flag;
        logic [RESULT_W-1:0] code;
    } sample_word_t;

    typedef enum logic [2:0] {
        ST_TRACK    = 3'b001,
        ST_HOLD     = 3'b010,
        ST_HANDOFF  = 3'b100
    } th_state_t;
endpackage

// [rtl/adc_sample_output.sv]
// digital core of the pipelined converter: sampling, correction, output latch
// Summary of operation
// - every rising conversion-clock edge samples the input and starts a conversion.
// - the track-hold stage tracks while the clock is low and holds while it is high.
// - internal timing comes from both rising and falling conversion-clock edges.
// - a new sample is accepted each cycle with several conversions in flight.
// - a result reaches the outputs three conversion cycles after its sampling edge.
// - four flash stages resolve 4, 4, 3 and 4 bits, the first three forming residues.
// - stage one returns to track only after stage two has entered hold.
// - correction sums the 15 raw bits with overlap into one 12-bit word.
// - the corrected word and range flag are registered together into the output latch.
// - all 4096 output codes are reachable.
// - a major disturbance marks the three conversions in the pipeline as suspect.
// - the output is twos complement by inverting the offset-binary top bit.
// - the range flag rises below the lowest or above the highest code.
// - the output-enable input decides whether data outputs are driven.
module adc_sample_output
    import adc_pkg::*;
#(
    parameter int DEPTH = LATENCY
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        conv_clk_pin,
    input  wire adc_pkg::raw_bits_t          flash_bits,
    input  wire logic                        disturb_event,
    input  wire logic                        output_drive_enable,
    input  wire logic                        out_ready,
    output logic                             track_hold_stage,
    output logic                             stage2_hold,
    output logic                             sample_strobe,
    output logic [adc_pkg::RESULT_W-1:0]     data_out,
    output logic                             range_exceeded_flag,
    output logic [adc_pkg::RESULT_W:0]       data_oe,
    output logic                             out_valid,
    output logic                             word_suspect,
    output logic                             overrun
);
    import adc_pkg::*;

    logic                clk_meta;
    logic                clk_sync;
    logic                clk_prev;
    logic                rise;
    logic                fall;
    logic                fall_seen;
    th_state_t           th_state;
    logic [SUM_W-1:0]    corr_sum;
    sample_word_t        corr_word;
    sample_word_t        pipe_word [DEPTH];
    logic [DEPTH-1:0]    pipe_valid;
    logic [DEPTH-1:0]    pipe_suspect;
    sample_word_t        stage_word_in [DEPTH];
    logic [DEPTH-1:0]    stage_valid_in;
    logic [DEPTH-1:0]    stage_suspect_in;
    sample_word_t        buf_word [2];
    logic [1:0]          buf_suspect;
    logic                wr_ptr;
    logic                rd_ptr;
    logic [1:0]          buf_count;
    logic                buf_push;
    logic                buf_pop;

    // conversion clock arrives from a pin, so it is synchronised before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
        end else begin
            clk_meta <= conv_clk_pin;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
        end
    end

    // both edges are decoded; the rising one starts work, the falling one re-arms tracking
    assign rise = clk_sync & ~clk_prev;
    assign fall = ~clk_sync & clk_prev;
    assign sample_strobe = rise;

    // a fall that lands while still in hold is remembered, so the handoff cannot miss it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fall_seen <= 1'b0;
        end else if (th_state == ST_HOLD) begin
            fall_seen <= fall;
        end else begin
            fall_seen <= 1'b0;
        end
    end

    // track-hold sequencing: hold on rise, hand residue to stage two, track again on fall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            th_state <= ST_TRACK;
        end else begin
            case (th_state)
                ST_TRACK:   if (rise) th_state <= ST_HOLD;
                ST_HOLD:    th_state <= ST_HANDOFF;
                ST_HANDOFF: if (fall || fall_seen) th_state <= ST_TRACK;
                default:    th_state <= ST_TRACK;
            endcase
        end
    end

    // hold level follows the state, so it stays high for the whole clock-high time
    assign track_hold_stage = (th_state != ST_TRACK);
    assign stage2_hold      = (th_state == ST_HANDOFF);

    // overlap correction: weighted estimates summed, shared redundancy removed
    always_comb begin
        corr_sum = (SUM_W'(flash_bits.s1) << STAGE1_SHIFT)
                 + (SUM_W'(flash_bits.s2) << STAGE2_SHIFT)
                 + (SUM_W'(flash_bits.s3) << STAGE3_SHIFT)
                 + (SUM_W'(flash_bits.s4) << STAGE4_SHIFT);
        corr_word = '0;
        if (corr_sum < OVERLAP_OFFSET) begin
            corr_word.code = CODE_ZERO;
            corr_word.range_exceeded_flag = 1'b1;
        end else if ((corr_sum - OVERLAP_OFFSET) > CODE_MAX) begin
            corr_word.code = CODE_TOP;
            corr_word.range_exceeded_flag = 1'b1;
        end else begin
            // every value from zero to full scale passes through unclipped
            corr_word.code = RESULT_W'(corr_sum - OVERLAP_OFFSET);
        end
        // twos complement: invert the top bit of offset binary
        corr_word.code[RESULT_W-1] = ~corr_word.code[RESULT_W-1];
    end

    // stage inputs: stage zero takes the corrected word, each later stage its neighbour
    assign stage_word_in[0]    = corr_word;
    assign stage_valid_in[0]   = 1'b1;
    assign stage_suspect_in[0] = disturb_event;

    // pipeline advances once per rising edge; one new sample per cycle
    // a glitch taints every conversion still in flight, so the set beats the shift
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
        if (i > 0) begin : g_link
            assign stage_word_in[i]    = pipe_word[i-1];
            assign stage_valid_in[i]   = pipe_valid[i-1];
            assign stage_suspect_in[i] = pipe_suspect[i-1];
        end
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pipe_word[i]    <= '0;
                pipe_valid[i]   <= 1'b0;
                pipe_suspect[i] <= 1'b0;
            end else begin
                if (rise) begin
                    pipe_word[i]    <= stage_word_in[i];
                    pipe_valid[i]   <= stage_valid_in[i];
                    pipe_suspect[i] <= stage_suspect_in[i];
                end
                if (disturb_event) begin
                    pipe_suspect[i] <= 1'b1;
                end
            end
        end
    end

    // two-entry buffer absorbs a stalled receiver; word leaves after the third rise
    assign buf_push = rise & pipe_valid[DEPTH-1];
    assign buf_pop  = out_valid & out_ready;
    assign overrun  = buf_push & (buf_count == 2'd2) & ~buf_pop;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr      <= 1'b0;
            rd_ptr      <= 1'b0;
            buf_count   <= 2'd0;
            buf_suspect <= '0;
            buf_word[0] <= '0;
            buf_word[1] <= '0;
        end else begin
            // full buffer drops the newest word and flags overrun; the converter cannot stall
            if (buf_push && (buf_count != 2'd2 || buf_pop)) begin
                buf_word[wr_ptr]    <= pipe_word[DEPTH-1];
                buf_suspect[wr_ptr] <= pipe_suspect[DEPTH-1];
                wr_ptr              <= ~wr_ptr;
            end
            if (buf_pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (buf_push && (buf_count != 2'd2 || buf_pop) && !buf_pop) begin
                buf_count <= buf_count + 2'd1;
            end else if (buf_pop && !(buf_push && (buf_count != 2'd2 || buf_pop))) begin
                buf_count <= buf_count - 2'd1;
            end
        end
    end

    // handshake valid stays combinational so the receiver sees a word the cycle it lands
    assign out_valid = (buf_count != 2'd0);

    // output latch: word and flag always captured together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out            <= '0;
            range_exceeded_flag <= 1'b0;
            word_suspect        <= 1'b0;
        end else begin
            data_out            <= buf_word[rd_ptr].code;
            range_exceeded_flag <= buf_word[rd_ptr].range_exceeded_flag;
            word_suspect        <= buf_suspect[rd_ptr] & out_valid;
        end
    end

    // output enable is an external pin; drivers follow it across the whole bus
    logic oe_meta;
    logic oe_sync;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oe_meta <= 1'b0;
            oe_sync <= 1'b0;
        end else begin
            oe_meta <= output_drive_enable;
            oe_sync <= oe_meta;
        end
    end
    assign data_oe = {(RESULT_W+1){oe_sync}};
endmodule

// [verif/adc_sample_output_assertions.sv]
// concurrent checks on the converter output core ports
module adc_sample_output_assertions
    import adc_pkg::*;
(
    input wire logic                        sys_clk,
    input wire logic                        rst,
    input wire logic                        conv_clk_pin,
    input wire logic                        output_drive_enable,
    input wire logic                        out_ready,
    input wire logic                        track_hold_stage,
    input wire logic                        stage2_hold,
    input wire logic                        sample_strobe,
    input wire logic [adc_pkg::RESULT_W-1:0] data_out,
    input wire logic                        range_exceeded_flag,
    input wire logic [adc_pkg::RESULT_W:0]  data_oe,
    input wire logic                        out_valid,
    input wire logic                        overrun
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // receiver holding off while a word waits
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    sequence s_oe_on;
        output_drive_enable [*4];
    endsequence
    property p_strobe_once; sample_strobe |=> !sample_strobe [*3]; endproperty
    property p_strobe_rise; $rose(conv_clk_pin) |-> ##[2:3] sample_strobe; endproperty
    property p_hold; sample_strobe |=> track_hold_stage; endproperty
    property p_track; !conv_clk_pin [*5] |-> !track_hold_stage; endproperty
    property p_release; $fell(track_hold_stage) |-> $past(stage2_hold); endproperty
    property p_oe_on; s_oe_on |-> &data_oe; endproperty
    property p_oe_off; !output_drive_enable [*4] |-> data_oe == '0; endproperty
    property p_overrun; overrun |-> out_valid && !out_ready; endproperty
    property p_keep; s_stall |=> out_valid; endproperty
    // word and flag only move together, never once the head has been held for two cycles in a row
    property p_pair; s_stall ##1 s_stall |=> $stable({range_exceeded_flag, data_out}); endproperty
    property p_push; $rose(out_valid) |-> $past(sample_strobe); endproperty
    a_strobe_once: assert property (p_strobe_once) else $error("strobe repeated");
    a_strobe_rise: assert property (p_strobe_rise) else $error("edge not sampled");
    a_hold: assert property (p_hold) else $error("no hold after sample");
    a_track: assert property (p_track) else $error("holding while clock low");
    a_release: assert property (p_release) else $error("early return to track");
    a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
    a_oe_off: assert property (p_oe_off) else $error("outputs still driven");
    a_overrun: assert property (p_overrun) else $error("bad overrun");
    a_keep: assert property (p_keep) else $error("word lost in stall");
    a_pair: assert property (p_pair) else $error("output moved in stall");
    a_push: assert property (p_push) else $error("word not on a sample");
endmodule
bind adc_sample_output adc_sample_output_assertions u_chk (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .conv_clk_pin        (conv_clk_pin),
    .output_drive_enable (output_drive_enable),
    .out_ready           (out_ready),
    .track_hold_stage    (track_hold_stage),
    .stage2_hold         (stage2_hold),
    .sample_strobe       (sample_strobe),
    .data_out            (data_out),
    .range_exceeded_flag (range_exceeded_flag),
    .data_oe             (data_oe),
    .out_valid           (out_valid),
    .overrun             (overrun)
);

// [verif/conv_clock_source.sv]
// far-side model: conversion clock source and word receiver
module conv_clock_source #(
    parameter int HALF = 4
) (
    input  wire logic sys_clk,
    input  wire logic run,
    input  wire logic stall,
    output logic      conv_clk_pin = 1'b0,
    output logic      out_ready = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // clock stands low between bursts; one rise per 2*HALF cycles
    always @(posedge sys_clk) begin
        cnt <= run ? (cnt + 1) % (2 * HALF) : 0;
        conv_clk_pin <= run && ((cnt + 1) % (2 * HALF) >= HALF);
        out_ready <= !stall;
    end
endmodule

// [verif/testbench.sv]
// self-checking bench for the converter output core
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench
    import adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, disturb_event = 0, output_drive_enable = 1, run = 0, stall = 0;
    logic conv_clk_pin, out_ready, track_hold_stage, stage2_hold, sample_strobe, popq = 0;
    logic range_exceeded_flag, out_valid, word_suspect, overrun;
    logic [RESULT_W-1:0] data_out;
    logic [RESULT_W:0]   data_oe;
    raw_bits_t           flash_bits = '0;
    sample_word_t        last, prev;
    int bad_count = 0, comparisons = 0, words = 0, sus = 0, ovr = 0;
    adc_sample_output dut (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .conv_clk_pin        (conv_clk_pin),
        .flash_bits          (flash_bits),
        .disturb_event       (disturb_event),
        .output_drive_enable (output_drive_enable),
        .out_ready           (out_ready),
        .track_hold_stage    (track_hold_stage),
        .stage2_hold         (stage2_hold),
        .sample_strobe       (sample_strobe),
        .data_out            (data_out),
        .range_exceeded_flag (range_exceeded_flag),
        .data_oe             (data_oe),
        .out_valid           (out_valid),
        .word_suspect        (word_suspect),
        .overrun             (overrun)
    );
    conv_clock_source src (.sys_clk(sys_clk), .run(run), .stall(stall),
        .conv_clk_pin(conv_clk_pin), .out_ready(out_ready));
    always #(500.0 / CLK_MHZ) sys_clk = ~sys_clk;
    // a pop shows on data_out one cycle later, so capture is delayed a cycle
    always @(negedge sys_clk) begin
        if (popq) begin
            words++;
            sus += word_suspect;
            last = {range_exceeded_flag, data_out};
        end
        ovr += overrun;
        popq = out_valid && out_ready;
    end
    function automatic sample_word_t expect_word(raw_bits_t r);
        int s;
        s = (int'(r.s1) << 9) + (int'(r.s2) << 6) + (int'(r.s3) << 4) + int'(r.s4) - 'h248;
        expect_word.range_exceeded_flag = s < 0 || s > 4095;
        s = s < 0 ? 0 : (s > 4095 ? 4095 : s);
        expect_word.code = RESULT_W'(s) ^ 12'h800;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // n conversion periods, then wait for the receiver to empty the buffer unless stalled
    task automatic stream(int n);
        int i;
        if (n > 0) begin
            run = 1;
            repeat (n * 8) @(negedge sys_clk);
            run = 0;
        end
        for (i = 0; i < 60 && (i < 6 || (out_valid !== 1'b0 && !stall)); i++) @(negedge sys_clk);
        if (i == 60) begin
            bad_count++;
            print_verdict();
        end
        @(negedge sys_clk);
    endtask
    task automatic t_fill();
        flash_bits = '{4'h8, 4'h4, 3'h2, 4'h8};
        prev = expect_word(flash_bits);
        stream(5);
        `CHECK("words after start", 2, words)
        `CHECK("first word", prev, last)
        $display("test fill done");
    endtask
    task automatic t_codes();
        raw_bits_t tbl [5];
        tbl = '{'{4'h0, 4'h0, 3'h0, 4'h0}, '{4'hf, 4'hf, 3'h7, 4'hf}, '{4'h1, 4'h2, 3'h3, 4'h4},
                '{4'h8, 4'h9, 3'h0, 4'h7}, '{4'h1, 4'h1, 3'h0, 4'h8}};
        for (int k = 0; k < 5; k++) begin
            flash_bits = tbl[k];
            stream(1);
            `CHECK("word before latency", prev, last)
            stream(3);
            prev = expect_word(tbl[k]);
            `CHECK("corrected word", prev, last)
        end
        $display("test codes done");
    endtask
    task automatic t_misc();
        int w, o, s;
        output_drive_enable = 0;
        repeat (5) @(negedge sys_clk);
        `CHECK("drive off", 13'h0000, data_oe)
        output_drive_enable = 1;
        w = words;
        o = ovr;
        stall = 1;
        stream(4);
        `CHECK("drive on", 13'h1fff, data_oe)
        `CHECK("dropped words", o + 2, ovr)
        stall = 0;
        stream(0);
        `CHECK("kept words", w + 2, words)
        s = sus;
        disturb_event = 1;
        @(negedge sys_clk);
        disturb_event = 0;
        stream(4);
        `CHECK("suspect words", s + 3, sus)
        $display("test enable stall disturb done");
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 0;
        repeat (4) @(negedge sys_clk);
        t_fill();
        t_codes();
        t_misc();
        print_verdict();
    end
endmodule
